// ---- core/acct_pkg.sv ----
// Package: register map, field layout and timing for the ADC control and cascade block
package acct_pkg;
	localparam logic [3:0] ADDR_ADC_CTRL1  = 4'hc;
	localparam logic [3:0] ADDR_ADC_CTRL2  = 4'hd;
	localparam logic [3:0] ADDR_ADC_CTRL3  = 4'he;
	localparam logic [3:0] ADDR_PEAK_LEFT  = 4'ha;
	localparam logic [3:0] ADDR_PEAK_RIGHT = 4'hb;
	localparam logic [3:0] ADDR_STATUS     = 4'hf;
	localparam int         REG_W           = 10;
	localparam logic [9:0] CTRL_RESET      = 10'h000;
	// Control word fields
	localparam int CW_ADDR_LSB = 12;
	localparam int CW_RW_BIT   = 11;
	// Control 1
	localparam int C1_HPF      = 8;
	localparam int C1_PWRDN    = 7;
	localparam int C1_RATE     = 6;
	localparam logic [9:0] C1_WMASK = 10'h1c0;
	// Control 2
	localparam int C2_AUX_MST  = 9;
	localparam int C2_FMT_LSB  = 6;
	localparam int C2_WID_LSB  = 4;
	localparam int C2_AUXILIARY_DATA_ENABLE  = 3;
	localparam int C2_MUTE_R   = 1;
	localparam int C2_MUTE_L   = 0;
	localparam logic [9:0] C2_WMASK = 10'h3fb;
	// Control 3
	localparam int C3_SCL_LSB  = 6;
	localparam int C3_PEAK_EN  = 5;
	localparam logic [9:0] C3_WMASK = 10'h0ff;
	localparam int PEAK_LSB    = 4;
	localparam logic [2:0] FMT_AUX512 = 3'h7;
	localparam int FRAME_BITS  = 256;
	localparam int CHANNELS    = 32;
	localparam int SLOT_BITS   = FRAME_BITS / 8;
	// Internal clock scaling codes
	typedef enum logic [1:0] {
		SCL_X2A  = 2'b00,
		SCL_X1   = 2'b01,
		SCL_X2_3 = 2'b10,
		SCL_X2B  = 2'b11
	} acct_scale_t;
	typedef struct packed {
		logic        hpf_en;
		logic        adc_pwrdn;
		logic        rate_96k;
		logic        aux_master;
		logic [2:0]  format;
		logic [1:0]  word_width;
		logic        auxiliary_data_enable;
		logic        mute_r;
		logic        mute_l;
		acct_scale_t clk_scale;
		logic        peak_en;
		logic [2:0]  dac_test;
		logic [1:0]  adc_test;
	} acct_cfg_t;
	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} acct_sample_t;
endpackage

// ---- core/acct_frame_ram.sv ----
// Frame store: 8 slots of 32 bits each, registered read data
`timescale 1ns/1ps
module acct_frame_ram #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 32,
	parameter int AW    = 3
) (
	input  wire logic             clock,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ---- core/acct_top.sv ----
// ADC control registers, peak capture and dual-device cascade shift chain
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
// Contract
// R1 - Control words: address bits 15..12, R/W bit 11; ADC words at 1100, 1101, 1110.
// R2 - Control 1 bit 8: 0 passes ADC data, 1 applies high-pass filter.
// R3 - Control 1 bit 7: 0 runs ADC, 1 powers ADC section down.
// R4 - Control 1 bit 6 picks 48 or 96 kHz; bits 5..0 reserved zero.
// R5 - Control 2 bit 9 aux master; bits 8..6 pick the serial format.
// R6 - Control 3 bits 7..6 scale master clock: x2, x1, x2/3, x2.
// R7 - Control 3 bit 5 enables peak capture and readback; the code gates only capture with it, peak reads work with the bit clear.
// R8 - Host programs both devices to Auxiliary 512 format for cascade.
// R9 - Role pin low makes cascade master; high makes slave.
// R10 - Slave takes frame sync and bit clock from the master.
// R11 - Master generates frame sync and bit clock for host and slave.
// R12 - Each device is one 256-bit shift register per sample interval.
// R13 - Shift register loads previous interval ADC results at interval start.
// R14 - Master shifts out to host while shifting in slave's output.
// R15 - Host shifts DAC data into the slave register with bit clock.
// R16 - After 512 bits, shifted-in DAC data goes to the DACs; the code latches left and right after 32 and 64 bits and pulses valid after 256 bits.
// R17 - Both devices share master clock and power-down/reset.
// R18 - Frame carries 16 channels each way, 32 in total.
// R19 - Peak is 6-bit attenuation, 0 to -63 dB, in upper bits.
// R20 - Reading a peak register clears it, restarting tracking.
// R21 - Aux bit and frame clocks output in master, input in slave.
// R22 - Control 2 width bits 5..4, aux data bit 3, mutes bits 1..0.
// R23 - Software keeps test-mode fields at zero, no reserved encodings.
module acct_top
	import acct_pkg::*;
#(
	parameter int BCLK_DIV = 2
) (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic                   role_slave_pin,
	input  wire logic                   powerdown_reset_pin,
	input  wire acct_pkg::acct_sample_t adc_sample,
	input  wire logic                   adc_sample_valid,
	output acct_pkg::acct_sample_t      dac_sample,
	output logic                        dac_sample_valid,
	output acct_pkg::acct_cfg_t         cfg,
	output logic [1:0]                  internal_core_clock_mult,
	output logic [1:0]                  internal_core_clock_div,
	input  wire logic                   bclk_in,
	input  wire logic                   fsync_in,
	output logic                        bclk_out,
	output logic                        bclk_oe,
	output logic                        fsync_out,
	output logic                        fsync_oe,
	input  wire logic                   cascade_sdata_in,
	output logic                        cascade_sdata_out,
	input  wire logic                   auxiliary_bit_clock_in,
	output logic                        auxiliary_bit_clock_out,
	output logic                        auxiliary_bit_clock_oe,
	input  wire logic                   auxiliary_frame_clock_in,
	output logic                        auxiliary_frame_clock_out,
	output logic                        auxiliary_frame_clock_oe
);
	import acct_pkg::*;

	// Bus and register state
	logic [9:0]  c1_q, c1_d, c2_q, c2_d, c3_q, c3_d;
	logic [5:0]  peak_l_q, peak_l_d, peak_r_q, peak_r_d;
	logic [31:0] rdata_q, rdata_d;
	logic        ack_q, ack_d;
	logic        is_slave_q, is_slave_d;
	logic        rst_seen_q, rst_seen_d;

	// Pin synchronisers
	logic [1:0] sy_bclk_q, sy_fs_q, sy_sd_q, sy_role_q, sy_pdr_q;
	logic       bclk_prev_q, fs_prev_q;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sy_bclk_q   <= 2'h0;
			sy_fs_q     <= 2'h0;
			sy_sd_q     <= 2'h0;
			sy_pdr_q    <= 2'h3;
			bclk_prev_q <= 1'b0;
			fs_prev_q   <= 1'b0;
		end else begin
			sy_bclk_q   <= {sy_bclk_q[0], bclk_in};
			sy_fs_q     <= {sy_fs_q[0], fsync_in};
			sy_sd_q     <= {sy_sd_q[0], cascade_sdata_in};
			sy_pdr_q    <= {sy_pdr_q[0], powerdown_reset_pin};
			bclk_prev_q <= sy_bclk_q[1];
			fs_prev_q   <= sy_fs_q[1];
		end
	end

	// Role sync runs through reset so the pin is settled when reset lifts
	always_ff @(posedge clock) begin
		sy_role_q <= {sy_role_q[0], role_slave_pin};
	end

	// Decoded configuration
	always_comb begin
		cfg.hpf_en                = c1_q[C1_HPF];       // R2
		cfg.adc_pwrdn             = c1_q[C1_PWRDN];     // R3
		cfg.rate_96k              = c1_q[C1_RATE];      // R4
		cfg.aux_master            = c2_q[C2_AUX_MST];   // R5
		cfg.format                = c2_q[C2_FMT_LSB +: 3]; // R5
		cfg.word_width            = c2_q[C2_WID_LSB +: 2]; // R22
		cfg.auxiliary_data_enable = c2_q[C2_AUXILIARY_DATA_ENABLE];   // R22
		cfg.mute_r                = c2_q[C2_MUTE_R];    // R22
		cfg.mute_l                = c2_q[C2_MUTE_L];    // R22
		cfg.clk_scale             = acct_scale_t'(c3_q[C3_SCL_LSB +: 2]);
		cfg.peak_en               = c3_q[C3_PEAK_EN];   // R7
		cfg.dac_test              = c3_q[4:2];
		cfg.adc_test              = c3_q[1:0];
	end

	// Internal clock ratio as multiplier over divider
	always_comb begin
		case (cfg.clk_scale) // R6
			SCL_X1: begin
				internal_core_clock_mult = 2'd1;
				internal_core_clock_div  = 2'd1;
			end
			SCL_X2_3: begin
				internal_core_clock_mult = 2'd2;
				internal_core_clock_div  = 2'd3;
			end
			default: begin
				internal_core_clock_mult = 2'd2;
				internal_core_clock_div  = 2'd1;
			end
		endcase
	end

	// Peak tracking on the 24-bit sample magnitude
	function automatic logic [5:0] peak_atten(input logic [23:0] s);
		logic [23:0] m;
		logic [5:0]  a;
		m = s[23] ? ~s : s;
		a = 6'd23;
		for (int i = 0; i < 23; i++) begin
			if (m[i]) begin
				a = 6'(22 - i);
			end
		end
		return a;
	endfunction

	// Register file and Avalon slave; one wait cycle per access
	wire acc = (avs_read || avs_write) && !ack_q;
	always_comb begin
		c1_d       = c1_q;
		c2_d       = c2_q;
		c3_d       = c3_q;
		peak_l_d   = peak_l_q;
		peak_r_d   = peak_r_q;
		rdata_d    = rdata_q;
		ack_d      = acc;
		is_slave_d = is_slave_q;
		rst_seen_d = 1'b1;
		if (!rst_seen_q) begin
			is_slave_d = sy_role_q[1]; // R9
		end
		if (acc && avs_write) begin // R1
			case (avs_address)
				ADDR_ADC_CTRL1: c1_d = avs_writedata[9:0] & C1_WMASK; // R4
				ADDR_ADC_CTRL2: c2_d = avs_writedata[9:0] & C2_WMASK;
				ADDR_ADC_CTRL3: c3_d = avs_writedata[9:0] & C3_WMASK;
				default: ;
			endcase
		end
		if (acc && avs_read) begin
			rdata_d = 32'h0;
			case (avs_address)
				ADDR_ADC_CTRL1: rdata_d[9:0] = c1_q;
				ADDR_ADC_CTRL2: rdata_d[9:0] = c2_q;
				ADDR_ADC_CTRL3: rdata_d[9:0] = c3_q;
				ADDR_PEAK_LEFT: begin
					rdata_d[PEAK_LSB +: 6] = peak_l_q; // R19
					peak_l_d = 6'h3f; // R20
				end
				ADDR_PEAK_RIGHT: begin
					rdata_d[PEAK_LSB +: 6] = peak_r_q; // R19
					peak_r_d = 6'h3f; // R20
				end
				ADDR_STATUS: rdata_d = {29'h0, sy_pdr_q[1], is_slave_q,
					(cfg.format == FMT_AUX512)};
				default: ;
			endcase
		end
		if (cfg.peak_en && adc_sample_valid && !cfg.adc_pwrdn) begin // R7
			if (peak_atten(adc_sample.left) < peak_l_d) begin
				peak_l_d = peak_atten(adc_sample.left);
			end
			if (peak_atten(adc_sample.right) < peak_r_d) begin
				peak_r_d = peak_atten(adc_sample.right);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			c1_q       <= CTRL_RESET;
			c2_q       <= CTRL_RESET;
			c3_q       <= CTRL_RESET;
			peak_l_q   <= 6'h3f;
			peak_r_q   <= 6'h3f;
			rdata_q    <= 32'h0;
			ack_q      <= 1'b0;
			is_slave_q <= 1'b0;
			rst_seen_q <= 1'b0;
		end else begin
			c1_q       <= c1_d;
			c2_q       <= c2_d;
			c3_q       <= c3_d;
			peak_l_q   <= peak_l_d;
			peak_r_q   <= peak_r_d;
			rdata_q    <= rdata_d;
			ack_q      <= ack_d;
			is_slave_q <= is_slave_d;
			rst_seen_q <= rst_seen_d;
		end
	end

	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign avs_readdata    = rdata_q;

	// Cascade: one 256-bit register per device, kept as eight 32-bit slots
	logic        cas_on;
	logic        run;
	logic [7:0]  div_q, div_d, bit_q, bit_d;
	logic        mbclk_q, mbclk_d, mfs_q, mfs_d;
	logic        tx_q, tx_d;
	logic [31:0] sh_q, sh_d, sh_in;
	logic [2:0]  slot_q, slot_d;
	logic        rise, fall, fs_rise;
	logic        ram_we;
	logic [31:0] ram_rdata;
	acct_sample_t adc_hold_q, adc_hold_d, dac_q, dac_d;
	logic        dac_v_q, dac_v_d;

	assign cas_on = (cfg.format == FMT_AUX512) && sy_pdr_q[1]; // R8 R17
	assign run    = cas_on && !cfg.adc_pwrdn;                 // R3
	assign sh_in  = {sh_q[30:0], sy_sd_q[1]};                 // R14 R15

	always_comb begin
		div_d   = div_q;
		mbclk_d = mbclk_q;
		rise    = 1'b0;
		fall    = 1'b0;
		if (!is_slave_q) begin // R11
			div_d = (div_q == 8'(BCLK_DIV - 1)) ? 8'h0 : div_q + 8'h1;
			if (div_q == 8'(BCLK_DIV - 1) && run) begin
				mbclk_d = !mbclk_q;
				rise    = !mbclk_q;
				fall    = mbclk_q;
			end
		end else begin // R10
			rise = sy_bclk_q[1] && !bclk_prev_q && run;
			fall = !sy_bclk_q[1] && bclk_prev_q && run;
		end
	end

	// Slave frame start comes from the master's frame sync
	assign fs_rise = is_slave_q ? (sy_fs_q[1] && !fs_prev_q) : (bit_q == 8'h0);

	always_comb begin
		bit_d      = bit_q;
		slot_d     = slot_q;
		sh_d       = sh_q;
		tx_d       = tx_q;
		mfs_d      = mfs_q;
		ram_we     = 1'b0;
		adc_hold_d = adc_sample_valid ? adc_sample : adc_hold_q; // R13
		dac_d      = dac_q;
		dac_v_d    = 1'b0;
		if (fall) begin
			tx_d  = sh_q[31];
			mfs_d = (bit_q == 8'h0) && !is_slave_q;
		end
		if (rise) begin
			sh_d   = sh_in; // R14 R15
			bit_d  = bit_q + 8'h1; // R12
			if (bit_q[4:0] == 5'h1f) begin
				ram_we = 1'b1;
				slot_d = slot_q + 3'h1;
				case (slot_q)
					3'h0: sh_d = {adc_hold_q.right, 8'h0};
					3'h7: sh_d = {adc_hold_q.left, 8'h0}; // R13
					default: sh_d = ram_rdata;
				endcase
				if (bit_q == 8'hff) begin // R16
					dac_v_d = 1'b1;
				end
				if (slot_q == 3'h0) begin
					dac_d.left = sh_q[30:7]; // R18
				end
				if (slot_q == 3'h1) begin
					dac_d.right = sh_q[30:7];
				end
			end
		end
		if (!run) begin
			bit_d  = 8'h0;
			slot_d = 3'h0;
		end else if (is_slave_q && fs_rise) begin
			bit_d  = 8'h0;
			slot_d = 3'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_q      <= 8'h0;
			mbclk_q    <= 1'b0;
			mfs_q      <= 1'b0;
			bit_q      <= 8'h0;
			slot_q     <= 3'h0;
			sh_q       <= 32'h0;
			tx_q       <= 1'b0;
			adc_hold_q <= '0;
			dac_q      <= '0;
			dac_v_q    <= 1'b0;
		end else begin
			div_q      <= div_d;
			mbclk_q    <= mbclk_d;
			mfs_q      <= mfs_d;
			bit_q      <= bit_d;
			slot_q     <= slot_d;
			sh_q       <= sh_d;
			tx_q       <= tx_d;
			adc_hold_q <= adc_hold_d;
			dac_q      <= dac_d;
			dac_v_q    <= dac_v_d;
		end
	end

	// Middle slots hold auxiliary channels carried through the chain
	acct_frame_ram #(
		.DEPTH (8),
		.WIDTH (32),
		.AW    (3)
	) u_frame (
		.clock (clock),
		.we    (ram_we),
		.waddr (slot_q),
		.wdata (sh_in),
		.raddr (slot_q + 3'h1),
		.rdata (ram_rdata)
	);

	// R11 R10: clock pins driven only by the master
	assign bclk_out          = mbclk_q;
	assign bclk_oe           = !is_slave_q && cas_on;
	assign fsync_out         = mfs_q;
	assign fsync_oe          = !is_slave_q && cas_on;
	assign cascade_sdata_out = tx_q;
	assign dac_sample        = dac_q;
	assign dac_sample_valid  = dac_v_q;

	// Aux clocks follow the Control 2 aux master bit
	assign auxiliary_bit_clock_out   = mbclk_q;
	assign auxiliary_bit_clock_oe    = cfg.aux_master; // R21
	assign auxiliary_frame_clock_out = mfs_q;
	assign auxiliary_frame_clock_oe  = cfg.aux_master; // R21
endmodule

// ---- verification/acct_checker.sv ----
// Port assertions for the ADC control and cascade block
`timescale 1ns/1ps
module acct_checker
	import acct_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst_n,
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [31:0]         avs_readdata,
	input  wire logic                avs_waitrequest,
	input  wire logic                dac_sample_valid,
	input  wire acct_pkg::acct_cfg_t cfg,
	input  wire logic [1:0]          internal_core_clock_mult,
	input  wire logic [1:0]          internal_core_clock_div,
	input  wire logic                bclk_oe,
	input  wire logic                fsync_oe,
	input  wire logic                auxiliary_bit_clock_oe,
	input  wire logic                auxiliary_frame_clock_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire logic acc = (avs_read | avs_write) & !avs_waitrequest;

	a_wait_one_cycle: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held past one cycle");
	a_idle_no_wait: assert property (!(avs_read | avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	a_unmapped_zero: assert property (acc && avs_read && avs_address < 4'ha |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl1_decode: assert property (acc && avs_write && avs_address == 4'hc |=>
		{cfg.hpf_en, cfg.adc_pwrdn, cfg.rate_96k} == $past(avs_writedata[8:6]))
		else $error("control 1 fields wrong");
	a_ctrl2_decode: assert property (acc && avs_write && avs_address == 4'hd |=>
		{cfg.aux_master, cfg.format, cfg.word_width, cfg.auxiliary_data_enable, cfg.mute_r,
		cfg.mute_l} == {$past(avs_writedata[9:3]), $past(avs_writedata[1:0])})
		else $error("control 2 fields wrong");
	a_ctrl3_decode: assert property (acc && avs_write && avs_address == 4'he |=>
		{cfg.clk_scale, cfg.peak_en} == $past(avs_writedata[7:5]))
		else $error("control 3 fields wrong");
	a_scale_ratio: assert property (internal_core_clock_mult == (cfg.clk_scale == SCL_X1 ? 2'h1 : 2'h2)
		&& internal_core_clock_div == (cfg.clk_scale == SCL_X2_3 ? 2'h3 : 2'h1))
		else $error("clock scaling ratio wrong");
	a_aux_oe_role: assert property ($stable(cfg.aux_master) |-> auxiliary_bit_clock_oe == cfg.aux_master
		&& auxiliary_frame_clock_oe == cfg.aux_master)
		else $error("aux clock direction wrong");
	a_link_oe_pair: assert property (bclk_oe == fsync_oe)
		else $error("frame and bit clock drive differ");
	a_peak_layout: assert property (acc && avs_read && avs_address inside {4'ha, 4'hb} |->
		avs_readdata[3:0] == 4'h0 && avs_readdata[31:10] == 22'h0)
		else $error("peak layout wrong");
	a_dac_pulse: assert property (dac_sample_valid |=> !dac_sample_valid)
		else $error("dac valid longer than one cycle");
endmodule

bind acct_top acct_checker u_chk (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.dac_sample_valid(dac_sample_valid), .cfg(cfg), .internal_core_clock_mult(internal_core_clock_mult),
	.internal_core_clock_div(internal_core_clock_div), .bclk_oe(bclk_oe), .fsync_oe(fsync_oe),
	.auxiliary_bit_clock_oe(auxiliary_bit_clock_oe),
	.auxiliary_frame_clock_oe(auxiliary_frame_clock_oe));

// ---- verification/acct_partner.sv ----
// Far side model: host serial port and the second codec of the chain
`timescale 1ns/1ps
module acct_partner (
	input  wire logic gen,
	input  wire logic bclk_out,
	output logic      bclk_in,
	output logic      fsync_in,
	output logic      sdata
);
	logic [7:0] pat;
	wire logic  bclk = gen ? bclk_in : bclk_out;
	initial begin
		bclk_in = 1'b0;
		fsync_in = 1'b0;
		sdata = 1'b0;
		pat = 8'h96;
		#3;
		forever begin
			wait (gen === 1'b1);
			for (int i = 0; i < 256; i++) begin
				fsync_in = (i == 0);
				#80 bclk_in = 1'b1;
				#80 bclk_in = 1'b0;
			end
			fsync_in = 1'b0;
		end
	end
	// Moves on the falling edge so the receiver samples a settled bit
	always @(negedge bclk) begin
		sdata = pat[7];
		pat = {pat[6:0], pat[7]};
	end
endmodule

// ---- verification/test_acct_top.sv ----
// Self-checking bench for the ADC control and cascade block
`timescale 1ns/1ps
module test_acct_top;
	import acct_pkg::*;
	localparam int DIV = 10;
	logic               clock, rst_n, avs_read, avs_write, avs_waitrequest, role_slave_pin, pd;
	logic               adc_sample_valid, dac_sample_valid, gen, bclk_in, fsync_in, bclk_out, bclk_oe;
	logic               fsync_out, fsync_oe, sdata_in, sdata_out, abo, aboe, afo, afoe;
	logic [3:0]         avs_address, ad;
	logic [31:0]        avs_writedata, avs_readdata, rd, lf, d, tw;
	logic [1:0]         mult, div;
	logic [9:0]         m [16];
	acct_sample_t       adc_sample, dac_sample;
	acct_cfg_t          cfg;
	int                 err_count, checks_done, cyc, bits;
	wire logic          lk = gen ? bclk_in : bclk_out;

	acct_top #(.BCLK_DIV(DIV)) dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.role_slave_pin(role_slave_pin), .powerdown_reset_pin(pd), .adc_sample(adc_sample),
		.adc_sample_valid(adc_sample_valid), .dac_sample(dac_sample),
		.dac_sample_valid(dac_sample_valid), .cfg(cfg), .internal_core_clock_mult(mult),
		.internal_core_clock_div(div), .bclk_in(bclk_in), .fsync_in(fsync_in),
		.bclk_out(bclk_out), .bclk_oe(bclk_oe), .fsync_out(fsync_out), .fsync_oe(fsync_oe),
		.cascade_sdata_in(sdata_in), .cascade_sdata_out(sdata_out),
		.auxiliary_bit_clock_in(1'b0), .auxiliary_bit_clock_out(abo),
		.auxiliary_bit_clock_oe(aboe), .auxiliary_frame_clock_in(1'b0),
		.auxiliary_frame_clock_out(afo), .auxiliary_frame_clock_oe(afoe));
	acct_partner u_far (.gen(gen), .bclk_out(bclk_out), .bclk_in(bclk_in), .fsync_in(fsync_in),
		.sdata(sdata_in));

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [9:0] mask(input logic [3:0] a);
		return (a == 4'hc) ? 10'h1c0 : (a == 4'hd) ? 10'h3fb : (a == 4'he) ? 10'h0ff : 10'h0;
	endfunction

	task automatic final_report;
		if (err_count == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low at a rising edge, then releases
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		chk({31'h0, n < 64}, 32'h1);
		if (wr && !(a inside {4'ha, 4'hb, 4'hf})) m[a] = wd[9:0] & mask(a);
	endtask
	task automatic chkcfg;
		logic [19:0] e;
		logic [3:0]  r;
		e = {m[12][8:6], m[13][9:6], m[13][5:3], m[13][1:0], m[14][7:0]};
		r = (m[14][7:6] == 2'h1) ? 4'h5 : (m[14][7:6] == 2'h2) ? 4'hb : 4'h9;
		chk({12'h0, cfg}, {12'h0, e});
		chk({28'h0, mult, div}, {28'h0, r});
	endtask
	// Frame length in clock cycles and link bit clocks, between two dac pulses
	task automatic span;
		logic b;
		int   n;
		n = 0;
		while (dac_sample_valid !== 1'b1 && n < 12000) begin
			@(negedge clock);
			n++;
		end
		cyc = 0;
		bits = 0;
		b = lk;
		do begin
			@(negedge clock);
			cyc++;
			if (lk && !b) begin
				bits++;
				tw = {tw[30:0], sdata_out};
			end
			b = lk;
		end while (dac_sample_valid !== 1'b1 && cyc < 12000);
	endtask
	// Partner sends a rotating byte, so every word in or out repeats one byte
	task automatic chkdat;
		chk(tw, {4{dac_sample.left[7:0]}});
		chk({31'h0, dac_sample.left == dac_sample.right
			&& dac_sample.left == {3{dac_sample.left[7:0]}}
			&& $countones(dac_sample.left[7:0]) == 4}, 32'h1);
	endtask
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		foreach (m[i]) m[i] = 10'h0;
		repeat (4) @(posedge clock);
	endtask

	initial begin
		{rst_n, avs_read, avs_write, role_slave_pin, adc_sample_valid, gen} = '0;
		{avs_address, avs_writedata, adc_sample} = '0;
		pd = 1'b1;
		lf = 32'h712c;
		err_count = 0;
		checks_done = 0;
		do_reset();
		for (int a = 0; a < 15; a++) begin
			bus(1'b0, 4'(a), 32'h0);
			chk(rd, (a == 10 || a == 11) ? 32'h3f0 : {22'h0, m[a]});
		end
		for (int i = 0; i < 40; i++) begin
			lf = lfsr(lf);
			ad = (lf[3:0] inside {4'ha, 4'hb, 4'hf}) ? 4'hc : lf[3:0];
			d = lf >> 4;
			if (ad == 4'he) d[4:0] = 5'h0;
			if (ad == 4'hd && d[5:4] == 2'h3) d[5] = 1'b0;
			bus(1'b1, ad, d);
			bus(1'b0, ad, 32'h0);
			chk(rd, {22'h0, m[ad]});
			chkcfg();
		end
		bus(1'b1, 4'hc, 32'h0);
		bus(1'b1, 4'he, 32'h0);
		bus(1'b1, 4'hd, 32'h3c0);
		bus(1'b0, 4'hf, 32'h0);
		chk({29'h0, rd[2:0]}, 32'h5);
		chkcfg();
		chk({28'h0, bclk_oe, fsync_oe, aboe, afoe}, 32'hf);
		span();
		chk(cyc, 512 * DIV);
		chk(bits, 256);
		chkdat();
		@(posedge clock);
		pd <= 1'b0;
		repeat (8) @(posedge clock);
		chk({30'h0, bclk_oe, fsync_oe}, 32'h0);
		pd <= 1'b1;
		bus(1'b1, 4'he, 32'h20);
		@(posedge clock);
		adc_sample <= {24'h7fffff, 24'h400000};
		adc_sample_valid <= 1'b1;
		@(posedge clock);
		adc_sample_valid <= 1'b0;
		repeat (4) @(posedge clock);
		for (int k = 10; k < 12; k++) begin
			bus(1'b0, 4'(k), 32'h0);
			chk({31'h0, rd[9:4] < 6'h3f}, 32'h1);
			bus(1'b0, 4'(k), 32'h0);
			chk(rd, 32'h3f0);
		end
		role_slave_pin <= 1'b1;
		do_reset();
		bus(1'b1, 4'hd, 32'h1c0);
		bus(1'b0, 4'hf, 32'h0);
		chk({29'h0, rd[2:0]}, 32'h7);
		gen = 1'b1;
		span();
		chk({30'h0, bclk_oe, fsync_oe, aboe}, 32'h0);
		span();
		chk({31'h0, cyc > 5115 && cyc < 5125}, 32'h1);
		chkdat();
		gen = 1'b0;
		final_report();
	end

	initial begin
		#700000;
		err_count++;
		final_report();
	end
endmodule
